// *** logic/fill_seq_pkg.sv ***
package fill_seq_pkg;
  // command codes
  localparam logic [7:0] CMD_UNLOCK = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  localparam logic [7:0] CMD_SOLID_FILL = 8'hF4;
  localparam logic [7:0] CMD_FILL_LEVEL = 8'hF5;
  localparam logic [7:0] CMD_SEQ_OPT = 8'hF9;
  localparam logic [7:0] CMD_OSC_TEST = 8'hFB;
  localparam logic [7:0] CMD_RD_STATE = 8'hFC;
  localparam logic [7:0] CMD_RD_POWER = 8'hFD;
  // reset values
  localparam logic [7:0] SOLID_FILL_RST = 8'h00;
  localparam logic [5:0] LEVEL_RST = 6'h00;
  localparam logic [7:0] SEQ_OPT_RST = 8'h12;
  localparam logic [7:0] OSC_TEST_RST = 8'h00;
  // field positions
  localparam int FILL_EN_BIT = 0;
  localparam int HOLD_BIT = 5;
  localparam int GATE_ON_DIS_BIT = 2;
  localparam int BLANK_LVD_BIT = 1;
  localparam int SKIP_WAIT_BIT = 0;
  localparam int DIV_EN_BIT = 7;
  localparam int DIV_OE_BIT = 6;
  localparam int LEVEL_W = 6;
  localparam int RAIL_W = 8;
  // fill state lasts this many frames when not held
  localparam logic [1:0] CLEAR_FRAMES = 2'd2;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PWR_UP = 3'b001,
    ST_CLEAR = 3'b010,
    ST_WAIT_DISP = 3'b011,
    ST_DISPLAY = 3'b100,
    ST_DISP_BLK = 3'b101,
    ST_PWR_DOWN = 3'b110
  } seq_state_type;
endpackage

// *** logic/osc_div_test.sv ***
`timescale 1ns/1ns
module osc_div_test
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic div_en,
  input wire logic out_en,
  output logic test_out,
  output logic test_oe
);
  // halve the oscillator while enabled
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      test_out <= 1'b0;
    else if (div_en)
      test_out <= ~test_out;
    else
      test_out <= 1'b0;
  end

  // pad driver enable
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      test_oe <= 1'b0;
    else
      test_oe <= out_en;
  end
endmodule

// *** logic/display_test_fsm_control_regs.sv ***
`timescale 1ns/1ns
//Contract
//- solid fill bit replaces frame memory pixels
//- three fill levels red green blue, six bits
//- without hold, fill state lasts two frames
//- with hold, fill state waits for power-off
//- gate-all-on at power-off unless suppressed
//- low-voltage monitor in blank state, default on
//- skip bit bypasses display-wait state
//- oscillator halving enabled by top bit
//- test pad driver enabled by bit six
//- state readback gives state code low bits
//- power readback gives rail enables as two nibbles, high then low
module display_test_fsm_control_regs
#(
  parameter int PIX_W = 18
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic power_on_req,
  input wire logic power_off_req,
  input wire logic blank_req,
  input wire logic frame_tick,
  input wire logic lvd_alarm,
  input wire logic [PIX_W-1:0] mem_pixel,
  output logic [PIX_W-1:0] pixel_out,
  output logic [7:0] rail_en,
  output logic panel_gate_driver_all_on,
  output logic lvd_shutdown,
  output logic osc_test_out,
  output logic osc_test_oe
);
  // refuse pixel widths other than exactly three fill levels
  if (PIX_W != 3 * fill_seq_pkg::LEVEL_W)
  begin
    $error("pixel width must hold three fill levels");
  end

  logic [7:0] cmd_q;
  logic [1:0] idx_q;
  logic unlock_q;
  logic fill_en_q;
  logic [5:0] lvl_r_q;
  logic [5:0] lvl_g_q;
  logic [5:0] lvl_b_q;
  logic [7:0] seq_opt_q;
  logic [7:0] osc_q;
  logic [1:0] frames_q;
  fill_seq_pkg::seq_state_type state_q;
  fill_seq_pkg::seq_state_type state_d;
  logic wr_ok;
  logic hold;
  logic all_up;

  assign wr_ok = wr_strobe && unlock_q;
  assign hold = seq_opt_q[fill_seq_pkg::HOLD_BIT];
  assign all_up = &rail_en;

  // current command and parameter index
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_q <= 8'h00;
      idx_q <= 2'd0;
    end
    else if (cmd_strobe)
    begin
      cmd_q <= cmd_code;
      idx_q <= 2'd0;
    end
    else if ((wr_strobe || rd_strobe) && idx_q != 2'd3)
      idx_q <= idx_q + 2'd1;
  end

  // unlock key, any other value relocks
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      unlock_q <= 1'b0;
    else if (wr_strobe && cmd_q == fill_seq_pkg::CMD_UNLOCK && idx_q == 2'd0)
      unlock_q <= (wr_data == fill_seq_pkg::UNLOCK_KEY);
  end

  // protected write registers, unused bits dropped
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fill_en_q <= fill_seq_pkg::SOLID_FILL_RST[0];
      lvl_r_q <= fill_seq_pkg::LEVEL_RST;
      lvl_g_q <= fill_seq_pkg::LEVEL_RST;
      lvl_b_q <= fill_seq_pkg::LEVEL_RST;
      seq_opt_q <= fill_seq_pkg::SEQ_OPT_RST;
      osc_q <= fill_seq_pkg::OSC_TEST_RST;
    end
    else if (wr_ok && idx_q == 2'd0 && cmd_q == fill_seq_pkg::CMD_SOLID_FILL)
      fill_en_q <= wr_data[fill_seq_pkg::FILL_EN_BIT];
    else if (wr_ok && cmd_q == fill_seq_pkg::CMD_FILL_LEVEL)
    begin
      if (idx_q == 2'd0)
        lvl_r_q <= wr_data[5:0];
      else if (idx_q == 2'd1)
        lvl_g_q <= wr_data[5:0];
      else if (idx_q == 2'd2)
        lvl_b_q <= wr_data[5:0];
    end
    else if (wr_ok && idx_q == 2'd0 && cmd_q == fill_seq_pkg::CMD_SEQ_OPT)
      seq_opt_q <= wr_data & 8'h27;
    else if (wr_ok && idx_q == 2'd0 && cmd_q == fill_seq_pkg::CMD_OSC_TEST)
      osc_q <= wr_data & 8'hC0;
  end

  // readback of state and rail enables
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_strobe;
      if (rd_strobe)
      begin
        if (cmd_q == fill_seq_pkg::CMD_RD_STATE && idx_q == 2'd0)
          rd_data <= {5'b00000, state_q};
        else if (cmd_q == fill_seq_pkg::CMD_RD_POWER && idx_q == 2'd0)
          rd_data <= {4'h0, rail_en[7:4]};
        else if (cmd_q == fill_seq_pkg::CMD_RD_POWER && idx_q == 2'd1)
          rd_data <= {4'h0, rail_en[3:0]};
        else
          rd_data <= 8'h00;
      end
    end
  end

  // pixel source select
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pixel_out <= '0;
    else if (fill_en_q)
      pixel_out <= {lvl_r_q, lvl_g_q, lvl_b_q};
    else
      pixel_out <= mem_pixel;
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      fill_seq_pkg::ST_OFF:
        if (power_on_req)
          state_d = fill_seq_pkg::ST_PWR_UP;
      fill_seq_pkg::ST_PWR_UP:
        if (all_up)
          state_d = fill_seq_pkg::ST_CLEAR;
      fill_seq_pkg::ST_CLEAR:
        if (power_off_req)
          state_d = fill_seq_pkg::ST_PWR_DOWN;
        else if (!hold && frame_tick && frames_q == fill_seq_pkg::CLEAR_FRAMES - 2'd1)
        begin
          if (seq_opt_q[fill_seq_pkg::SKIP_WAIT_BIT])
            state_d = fill_seq_pkg::ST_DISPLAY;
          else
            state_d = fill_seq_pkg::ST_WAIT_DISP;
        end
      fill_seq_pkg::ST_WAIT_DISP:
        if (power_off_req)
          state_d = fill_seq_pkg::ST_PWR_DOWN;
        else if (frame_tick)
          state_d = fill_seq_pkg::ST_DISPLAY;
      fill_seq_pkg::ST_DISPLAY:
        if (power_off_req)
          state_d = fill_seq_pkg::ST_PWR_DOWN;
        else if (blank_req)
          state_d = fill_seq_pkg::ST_DISP_BLK;
      fill_seq_pkg::ST_DISP_BLK:
        if (power_off_req || (lvd_alarm && seq_opt_q[fill_seq_pkg::BLANK_LVD_BIT]))
          state_d = fill_seq_pkg::ST_PWR_DOWN;
        else if (!blank_req)
          state_d = fill_seq_pkg::ST_DISPLAY;
      fill_seq_pkg::ST_PWR_DOWN:
        if (rail_en == '0)
          state_d = fill_seq_pkg::ST_OFF;
      default:
        state_d = fill_seq_pkg::ST_OFF;
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      state_q <= fill_seq_pkg::ST_OFF;
    else
      state_q <= state_d;
  end

  // frames spent in the fill state
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      frames_q <= 2'd0;
    else if (state_q != fill_seq_pkg::ST_CLEAR)
      frames_q <= 2'd0;
    else if (frame_tick && frames_q != 2'd3)
      frames_q <= frames_q + 2'd1;
  end

  // rails come up one per frame, drop one per frame
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rail_en <= '0;
    else if (frame_tick && state_q == fill_seq_pkg::ST_PWR_UP)
      rail_en <= {rail_en[6:0], 1'b1};
    else if (frame_tick && state_q == fill_seq_pkg::ST_PWR_DOWN)
      rail_en <= {1'b0, rail_en[7:1]};
  end

  // gate-all-on during normal power-off, lvd shutdown flag
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      panel_gate_driver_all_on <= 1'b0;
      lvd_shutdown <= 1'b0;
    end
    else
    begin
      if (state_q != fill_seq_pkg::ST_PWR_DOWN && state_d == fill_seq_pkg::ST_PWR_DOWN)
      begin
        panel_gate_driver_all_on <= power_off_req &&
          !seq_opt_q[fill_seq_pkg::GATE_ON_DIS_BIT];
        lvd_shutdown <= !power_off_req;
      end
      else if (state_q != fill_seq_pkg::ST_PWR_DOWN)
      begin
        panel_gate_driver_all_on <= 1'b0;
        lvd_shutdown <= 1'b0;
      end
    end
  end

  osc_div_test u_osc
  (
    .mclk(mclk),
    .nrst(nrst),
    .div_en(osc_q[fill_seq_pkg::DIV_EN_BIT]),
    .out_en(osc_q[fill_seq_pkg::DIV_OE_BIT]),
    .test_out(osc_test_out),
    .test_oe(osc_test_oe)
  );
endmodule

// *** verif/fill_ctrl_properties.sv ***
`timescale 1ns/1ns
// watches the command port, sequencer flags and test pad
module fill_ctrl_properties
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic frame_tick,
  input wire logic power_off_req,
  input wire logic lvd_alarm,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] rail_en,
  input wire logic panel_gate_driver_all_on,
  input wire logic lvd_shutdown,
  input wire logic osc_test_out,
  input wire logic osc_test_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // read answers and readback padding
  a_read_answer: assert property (rd_strobe |=> rd_valid)
    else $error("read not answered");
  a_read_upper: assert property (rd_valid |-> rd_data[7:4] == 4'h0)
    else $error("readback upper bits set");
  // divided clock and its pad driver
  a_div_toggle: assert property (osc_test_out |=> !osc_test_out)
    else $error("test clock not halved");
  a_pad_steady: assert property (!wr_strobe [*2] |=> $stable(osc_test_oe))
    else $error("pad enable moved without write");
  // rails move one step per frame only
  a_rail_hold: assert property (!frame_tick |=> $stable(rail_en))
    else $error("rails moved without frame");
  a_rail_step: assert property (frame_tick && rail_en != 8'h00 && rail_en != 8'hff
    |=> rail_en != $past(rail_en)) else $error("rail ramp stalled");
  // power-down flags need their cause
  a_gate_cause: assert property ($rose(panel_gate_driver_all_on)
    |-> $past(power_off_req) && rail_en == 8'hff) else $error("gate all-on without power-off");
  a_lvd_cause: assert property ($rose(lvd_shutdown) |-> $past(lvd_alarm))
    else $error("shutdown without alarm");
endmodule

bind display_test_fsm_control_regs fill_ctrl_properties chk_u (.*);

// *** verif/fill_host.sv ***
`timescale 1ns/1ns
// host side of the command port, driven off the falling edge
module fill_host
(
  input wire logic mclk,
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic rd_strobe
);
  initial {cmd_strobe, wr_strobe, rd_strobe, cmd_code, wr_data} = '0;
  // one byte per call; on release both buses are inverted
  task automatic send(bit is_cmd, logic [7:0] v);
    @(negedge mclk);
    if (is_cmd) {cmd_strobe, cmd_code} = {1'b1, v};
    else {wr_strobe, wr_data} = {1'b1, v};
    @(negedge mclk);
    {cmd_strobe, wr_strobe} = 2'b00;
    cmd_code = ~cmd_code;
    wr_data = ~wr_data;
  endtask
  // key must precede protected writes
  task automatic unlock();
    send(1, fill_seq_pkg::CMD_UNLOCK);
    send(0, fill_seq_pkg::UNLOCK_KEY);
  endtask
  task automatic rd_req();
    @(negedge mclk) rd_strobe = 1;
    @(negedge mclk) rd_strobe = 0;
  endtask
endmodule

// *** verif/display_test_fsm_control_regs_tb.sv ***
`timescale 1ns/1ns
module display_test_fsm_control_regs_tb;
  logic mclk = 0;
  logic nrst = 0;
  logic [4:0] ctl = '0;
  logic [17:0] mem_pixel = '0;
  logic [17:0] pixel_out, lv;
  logic [7:0] cmd_code, wr_data, rd_data, rail_en;
  logic [7:0] opt = 8'h12;
  logic cmd_strobe, wr_strobe, rd_strobe, rd_valid, b;
  logic panel_gate_driver_all_on, lvd_shutdown, osc_test_out, osc_test_oe;
  logic [15:0] lf = 16'h5866;
  int n_errors = 0, total_checks = 0, cyc = 0, st = 0, nr = 0, cf = 0;
  wire power_on_req = ctl[0];
  wire power_off_req = ctl[1];
  wire blank_req = ctl[2];
  wire frame_tick = ctl[3];
  wire lvd_alarm = ctl[4];
  fill_host host_u (.*);
  display_test_fsm_control_regs dut_u (.*);
  always #10 mclk = ~mclk;
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random frame-memory pixels
  always @(negedge mclk)
  begin
    lf <= nx(lf);
    mem_pixel <= {lf, lf[1:0]};
  end
  // hang limit
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pix(bit f, logic [17:0] e);
    @(negedge mclk);
    check("pixel", pixel_out, f ? e : mem_pixel);
  endtask
  // state and rail readback against the model
  task automatic seq_chk();
    logic [7:0] r;
    r = 8'((1 << nr) - 1);
    host_u.send(1, 8'hFC);
    host_u.rd_req();
    check("state", rd_data, {5'b0, st[2:0]});
    check("rd_valid", rd_valid, 1);
    host_u.send(1, 8'hFD);
    host_u.rd_req();
    check("power1", rd_data, {4'b0, r[7:4]});
    host_u.rd_req();
    check("power2", rd_data, {4'b0, r[3:0]});
    check("rail_en", rail_en, r);
  endtask
  // one-cycle pulse on a sequencer input, then model step
  task automatic pulse(int i);
    @(negedge mclk) ctl[i] = 1;
    @(negedge mclk) ctl[i] = 0;
    if (i == 0 && st == 0) st = 1;
    if (i == 1 && st inside {2, 4, 5}) st = 6;
    if (i == 4 && st == 5 && opt[1]) st = 6;
    if (i == 3)
      case (st)
        1:
        begin
          nr++;
          st = (nr == 8) ? 2 : 1;
        end
        2:
        begin
          cf = opt[5] ? cf : cf + 1;
          if (cf == 2) st = opt[0] ? 4 : 3;
        end
        3: st = 4;
        6:
        begin
          nr--;
          st = (nr == 0) ? 0 : 6;
        end
        default: ;
      endcase
  endtask
  task automatic blk(bit v);
    @(negedge mclk) ctl[2] = v;
    st = v ? 5 : 4;
  endtask
  task automatic up(logic [7:0] o);
    if (o != 8'h12)
    begin
      host_u.send(1, 8'hF9);
      host_u.send(0, o);
    end
    opt = o;
    cf = 0;
    pulse(0);
    repeat (8) pulse(3);
    seq_chk();
    repeat (2) pulse(3);
    seq_chk();
    pulse(3);
    seq_chk();
  endtask
  task automatic down(int i, bit g, bit l);
    pulse(i);
    seq_chk();
    check("gate_all_on", panel_gate_driver_all_on, g);
    check("lvd_shutdown", lvd_shutdown, l);
    repeat (8) pulse(3);
    seq_chk();
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    @(negedge mclk) nrst = 1;
    seq_chk();
    host_u.send(1, 8'hF4);
    host_u.send(0, 8'h01);
    pix(0, 0);
    host_u.unlock();
    lv = {lf, lf[1:0]};
    host_u.send(1, 8'hF5);
    host_u.send(0, {2'b11, lv[17:12]});
    host_u.send(0, {2'b10, lv[11:6]});
    host_u.send(0, {2'b01, lv[5:0]});
    host_u.send(1, 8'hF4);
    host_u.send(0, 8'hFF);
    pix(1, lv);
    host_u.send(1, 8'hF4);
    host_u.send(0, 8'hFE);
    pix(0, 0);
    host_u.send(1, 8'hFF);
    host_u.send(0, 8'h5A);
    host_u.send(1, 8'hF4);
    host_u.send(0, 8'h01);
    pix(0, 0);
    host_u.unlock();
    for (int v = 1; v >= 0; v--)
    begin
      host_u.send(1, 8'hFB);
      host_u.send(0, v ? 8'hC0 : 8'h00);
      repeat (2) @(negedge mclk);
      b = osc_test_out;
      @(negedge mclk);
      check("osc_oe", osc_test_oe, v);
      check("osc_out", osc_test_out, v ? !b : 0);
    end
    up(8'h12);
    blk(1);
    seq_chk();
    down(4, 0, 1);
    @(negedge mclk) ctl[2] = 0;
    up(8'h21);
    down(1, 1, 0);
    up(8'h05);
    blk(1);
    pulse(4);
    seq_chk();
    blk(0);
    down(1, 0, 0);
    finish_test();
  end
endmodule
